// ===== asb_regs.svh
// constants for the skip/branch/alu instruction slice
`ifndef ASB_REGS_SVH
`define ASB_REGS_SVH
`define ASB_INSTR_W 14
`define ASB_DATA_W 8
`define ASB_FADDR_W 7
`define ASB_PC_W 15
`define ASB_LATCH_W 7
`define ASB_JUMP_W 11
`define ASB_DEST_BIT 7
`define ASB_LATCH_HI 6
`define ASB_LATCH_LO 3
`define ASB_SKIP_CYCLES 2
`define ASB_ACC_RST 8'h00
`define ASB_ZERO_RST 1'b0
`define ASB_PC_RST 15'h0000
`define ASB_MASK_FILE 14'h3F00
`define ASB_OPC_DEC 14'h0300
`define ASB_OPC_DECSZ 14'h0B00
`define ASB_OPC_INCSZ 14'h0F00
`define ASB_MASK_CLEAR_ACCUMULATOR_OP 14'h3FFC
`define ASB_OPC_CLEAR_ACCUMULATOR_OP 14'h0100
`define ASB_MASK_JUMP 14'h3800
`define ASB_OPC_JUMP 14'h2800
`define ASB_MASK_LIT 14'h3F00
`define ASB_OPC_IOR 14'h3800
`endif

// ===== asb_pkg.sv
// types for the skip/branch/alu instruction slice
`default_nettype none
`include "asb_regs.svh"
package asb_pkg;
   typedef enum logic [2:0] {
      ASB_OP_NONE = 3'h0,
      ASB_OP_DEC = 3'h1,
      ASB_OP_CLEAR_ACCUMULATOR_OP = 3'h2,
      ASB_OP_DECSZ = 3'h3,
      ASB_OP_INCSZ = 3'h4,
      ASB_OP_JUMP = 3'h5,
      ASB_OP_IOR = 3'h6
   } asb_op_e;
   typedef enum logic {
      ASB_ST_RUN = 1'b0,
      ASB_ST_NOP = 1'b1
   } asb_state_e;
   typedef logic [`ASB_DATA_W-1:0] asb_data_t;
endpackage : asb_pkg
`default_nettype wire

// ===== asb_alu_if.sv
// carrier between the decoder and the arithmetic unit
`default_nettype none
interface asb_alu_if;
   import asb_pkg::*;
   asb_op_e op;
   asb_data_t operand;
   asb_data_t acc;
   asb_data_t literal;
   asb_data_t result;
   logic is_zero;
   modport ctrl (output op, output operand, output acc, output literal,
                 input result, input is_zero);
   modport alu (input op, input operand, input acc, input literal,
                output result, output is_zero);
endinterface : asb_alu_if
`default_nettype wire

// ===== asb_alu.sv
// arithmetic unit for the instruction slice
`default_nettype none
module asb_alu (
   asb_alu_if.alu a
);
   import asb_pkg::*;
   always_comb begin
      case (a.op)
         ASB_OP_DEC, ASB_OP_DECSZ: a.result = a.operand - 8'h01;
         ASB_OP_INCSZ: a.result = a.operand + 8'h01;
         ASB_OP_CLEAR_ACCUMULATOR_OP: a.result = 8'h00;
         ASB_OP_IOR: a.result = a.acc | a.literal;
         default: a.result = a.operand;
      endcase
   end
   assign a.is_zero = (a.result == 8'h00);
endmodule : asb_alu
`default_nettype wire

// ===== asb_core.sv
// decode and execute of decrement, clear, skip, jump and or-literal
`default_nettype none
`include "asb_regs.svh"
module asb_core (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic i_exec,
   input wire logic [`ASB_INSTR_W-1:0] i_instr,
   input wire asb_pkg::asb_data_t i_file_rdata,
   input wire logic [`ASB_LATCH_W-1:0] i_program_counter_high_latch,
   output logic [`ASB_FADDR_W-1:0] o_file_raddr,
   output logic o_file_we,
   output logic [`ASB_FADDR_W-1:0] o_file_waddr,
   output asb_pkg::asb_data_t o_file_wdata,
   output asb_pkg::asb_data_t o_acc,
   output logic o_zero,
   output logic [`ASB_PC_W-1:0] o_pc,
   output logic o_squash
);
   import asb_pkg::*;

   asb_alu_if alu_bus ();
   asb_op_e op;
   asb_state_e state;
   logic live;
   logic dest_file;
   logic file_op;
   logic skip_op;
   logic skip;
   logic jump;
   logic [`ASB_PC_W-1:0] jump_target;

   asb_alu u_alu (
      .a(alu_bus)
   );

   always_comb begin
      op = ASB_OP_NONE;
      if ((i_instr & `ASB_MASK_FILE) == `ASB_OPC_DEC) op = ASB_OP_DEC;
      else if ((i_instr & `ASB_MASK_FILE) == `ASB_OPC_DECSZ) op = ASB_OP_DECSZ;
      else if ((i_instr & `ASB_MASK_FILE) == `ASB_OPC_INCSZ) op = ASB_OP_INCSZ;
      else if ((i_instr & `ASB_MASK_CLEAR_ACCUMULATOR_OP) == `ASB_OPC_CLEAR_ACCUMULATOR_OP) op = ASB_OP_CLEAR_ACCUMULATOR_OP;
      else if ((i_instr & `ASB_MASK_JUMP) == `ASB_OPC_JUMP) op = ASB_OP_JUMP;
      else if ((i_instr & `ASB_MASK_LIT) == `ASB_OPC_IOR) op = ASB_OP_IOR;
   end

   // read address goes straight out so the operand returns in the same cycle
   assign o_file_raddr = i_instr[`ASB_FADDR_W-1:0];
   assign alu_bus.op = op;
   assign alu_bus.operand = i_file_rdata;
   assign alu_bus.acc = o_acc;
   assign alu_bus.literal = i_instr[`ASB_DATA_W-1:0];

   // a squashed slot still advances the pc but changes no data state
   assign live = i_exec && (state == ASB_ST_RUN);
   assign o_squash = i_exec && (state == ASB_ST_NOP);
   assign dest_file = i_instr[`ASB_DEST_BIT];
   assign file_op = (op == ASB_OP_DEC) || (op == ASB_OP_DECSZ) || (op == ASB_OP_INCSZ);
   assign skip_op = (op == ASB_OP_DECSZ) || (op == ASB_OP_INCSZ);
   assign skip = live && skip_op && alu_bus.is_zero;
   assign jump = live && (op == ASB_OP_JUMP);
   assign jump_target = {i_program_counter_high_latch[`ASB_LATCH_HI:`ASB_LATCH_LO],
                         i_instr[`ASB_JUMP_W-1:0]};

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_acc <= `ASB_ACC_RST;
      end else if (live && ((op == ASB_OP_CLEAR_ACCUMULATOR_OP) || (op == ASB_OP_IOR) ||
                            (file_op && !dest_file))) begin
         o_acc <= alu_bus.result;
      end
   end

   // skip forms leave the flag alone
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_zero <= `ASB_ZERO_RST;
      end else if (live && ((op == ASB_OP_DEC) || (op == ASB_OP_CLEAR_ACCUMULATOR_OP) ||
                            (op == ASB_OP_IOR))) begin
         o_zero <= alu_bus.is_zero;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_file_we <= 1'b0;
         o_file_waddr <= '0;
         o_file_wdata <= 8'h00;
      end else begin
         o_file_we <= live && file_op && dest_file;
         if (live && file_op) begin
            o_file_waddr <= i_instr[`ASB_FADDR_W-1:0];
            o_file_wdata <= alu_bus.result;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         o_pc <= `ASB_PC_RST;
      end else if (i_exec) begin
         o_pc <= jump ? jump_target : o_pc + 15'h0001;
      end
   end

   // the prefetched word after a jump or a taken skip becomes a no-operation
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state <= ASB_ST_RUN;
      end else if (i_exec) begin
         case (state)
            ASB_ST_RUN: state <= (skip || jump) ? ASB_ST_NOP : ASB_ST_RUN;
            ASB_ST_NOP: state <= ASB_ST_RUN;
            default: state <= ASB_ST_RUN;
         endcase
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   property p_dec_acc;
      live && (op == ASB_OP_DEC) && !dest_file |=>
         (o_acc == 8'($past(i_file_rdata) - 8'h01)) && (o_zero == (o_acc == 8'h00));
   endproperty
   a_dec_acc: assert property (p_dec_acc) else $error("decrement result wrong");

   property p_dest_file;
      live && file_op && dest_file |=> o_file_we && $stable(o_acc) &&
         (o_file_waddr == $past(i_instr[`ASB_FADDR_W-1:0]));
   endproperty
   a_dest_file: assert property (p_dest_file) else $error("file destination ignored");

   property p_clear_accumulator_op;
      live && (op == ASB_OP_CLEAR_ACCUMULATOR_OP) |=> (o_acc == 8'h00) && o_zero && !o_file_we;
   endproperty
   a_clear_accumulator_op: assert property (p_clear_accumulator_op) else $error("clear accumulator failed");

   // judged from the operand itself so a broken zero detect cannot hide the miss
   property p_skip_taken;
      live && (op == ASB_OP_DECSZ) && (i_file_rdata == 8'h01) |=> (state == ASB_ST_NOP);
   endproperty
   a_skip_taken: assert property (p_skip_taken) else $error("skip did not squash");

   // a squashed slot behaves as a no-operation and only moves the pc on
   property p_squash_nop;
      o_squash |=> !o_file_we && $stable(o_acc) && $stable(o_zero);
   endproperty
   a_squash_nop: assert property (p_squash_nop) else $error("squash had effect");

   // wrap from all ones is the only operand that gives a zero sum
   property p_inc_skip;
      live && (op == ASB_OP_INCSZ) && (i_file_rdata == 8'hFF) |=> (state == ASB_ST_NOP);
   endproperty
   a_inc_skip: assert property (p_inc_skip) else $error("increment skip missed");

   property p_no_skip;
      live && skip_op && !alu_bus.is_zero |=> (state == ASB_ST_RUN);
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("nonzero result skipped");

   property p_skip_flags;
      live && skip_op |=> $stable(o_zero);
   endproperty
   a_skip_flags: assert property (p_skip_flags) else $error("skip changed zero flag");

   property p_jump_pc;
      jump |=> (o_pc[`ASB_JUMP_W-1:0] == $past(i_instr[`ASB_JUMP_W-1:0])) &&
         (o_pc[`ASB_PC_W-1:`ASB_JUMP_W] == $past(i_program_counter_high_latch[`ASB_LATCH_HI:`ASB_LATCH_LO]));
   endproperty
   a_jump_pc: assert property (p_jump_pc) else $error("jump target wrong");

   property p_jump_two;
      jump |=> (state == ASB_ST_NOP);
   endproperty
   a_jump_two: assert property (p_jump_two) else $error("jump did not discard");

   property p_ior;
      live && (op == ASB_OP_IOR) |=>
         (o_acc == ($past(o_acc) | $past(i_instr[`ASB_DATA_W-1:0]))) &&
         (o_zero == (o_acc == 8'h00));
   endproperty
   a_ior: assert property (p_ior) else $error("or literal wrong");

   property p_inc_acc;
      live && (op == ASB_OP_INCSZ) && !dest_file |=>
         (o_acc == 8'($past(i_file_rdata) + 8'h01));
   endproperty
   a_inc_acc: assert property (p_inc_acc) else $error("increment result wrong");

   property p_decsz_store;
      live && (op == ASB_OP_DECSZ) |=>
         (o_file_wdata == 8'($past(i_file_rdata) - 8'h01));
   endproperty
   a_decsz_store: assert property (p_decsz_store) else $error("skip store wrong");

   property p_dec_file;
      live && (op == ASB_OP_DEC) && dest_file |=>
         (o_file_wdata == 8'($past(i_file_rdata) - 8'h01)) &&
         (o_zero == (o_file_wdata == 8'h00));
   endproperty
   a_dec_file: assert property (p_dec_file) else $error("decrement to file wrong");

   // the write strobe must never fire for an accumulator destination
   property p_no_stray_write;
      !(live && file_op && dest_file) |=> !o_file_we;
   endproperty
   a_no_stray_write: assert property (p_no_stray_write) else $error("stray write");

   // every slot but a live jump, squashed ones included, costs exactly one pc step
   property p_pc_step;
      i_exec && !jump |=> (o_pc == 15'($past(o_pc) + 15'h0001));
   endproperty
   a_pc_step: assert property (p_pc_step) else $error("pc did not step");

   // a pending squash must wait for the next executed slot, not the next clock
   property p_idle_hold;
      !i_exec |=> $stable(o_pc) && $stable(o_acc) && $stable(o_zero) &&
         $stable(state) && !o_file_we;
   endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("idle clock changed state");
endmodule : asb_core
`default_nettype wire

// ===== alu_skip_branch_ops_test.sv
// self-checking bench for the skip/branch/alu instruction slice
`default_nettype none
module alu_skip_branch_ops_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic exec = 1'b0;
   logic [13:0] instr = 14'h0000;
   logic [7:0] rdata = 8'h00;
   logic [6:0] program_counter_high_latch = 7'h00;
   logic [6:0] raddr, waddr;
   logic we, zero, squash;
   logic [7:0] wdata, acc;
   logic [14:0] pc;
   logic [14:0] epc = 15'h0000;
   int n_fail = 0;
   int samples_checked = 0;
   asb_core u_dut (.i_clk(clk), .i_rstn(rstn), .i_exec(exec), .i_instr(instr),
      .i_file_rdata(rdata), .i_program_counter_high_latch(program_counter_high_latch), .o_file_raddr(raddr), .o_file_we(we),
      .o_file_waddr(waddr), .o_file_wdata(wdata), .o_acc(acc), .o_zero(zero),
      .o_pc(pc), .o_squash(squash));
   always #2.5 clk = ~clk;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   // one instruction slot; exec stays high so back-to-back slots never toggle it
   task automatic step(input logic [13:0] ins, input logic [7:0] rd, input logic sq);
      exec = 1'b1;
      instr = ins;
      rdata = rd;
      #1;
      chk("squash", {15'h0, sq}, {15'h0, squash});
      chk("raddr", {9'h0, ins[6:0]}, {9'h0, raddr});
      @(posedge clk);
      #1;
      if (!sq && (ins & 14'h3800) == 14'h2800) epc = {program_counter_high_latch[6:3], ins[10:0]};
      else epc = epc + 15'h1;
      chk("pc", {1'b0, epc}, {1'b0, pc});
   endtask : step
   task automatic idle();
      exec = 1'b0;
      @(posedge clk);
      #1;
   endtask : idle
   task automatic res(input logic [7:0] a, input logic z, input logic w);
      chk("acc", {8'h0, a}, {8'h0, acc});
      chk("zero", {15'h0, z}, {15'h0, zero});
      chk("we", {15'h0, w}, {15'h0, we});
   endtask : res
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      chk("waddr", {9'h0, a}, {9'h0, waddr});
      chk("wdata", {8'h0, d}, {8'h0, wdata});
   endtask : wr
   task automatic t_dec();
      res(8'h00, 1'b0, 1'b0);
      chk("pc", 16'h0000, {1'b0, pc});
      step(14'h0305, 8'h01, 1'b0);
      res(8'h00, 1'b1, 1'b0);
      step(14'h0385, 8'h00, 1'b0);
      res(8'h00, 1'b0, 1'b1);
      wr(7'h05, 8'hFF);
      idle();
      res(8'h00, 1'b0, 1'b0);
   endtask : t_dec
   task automatic t_lit();
      step(14'h385A, 8'h00, 1'b0);
      res(8'h5A, 1'b0, 1'b0);
      step(14'h0100, 8'h33, 1'b0);
      res(8'h00, 1'b1, 1'b0);
      step(14'h3880, 8'h00, 1'b0);
      res(8'h80, 1'b0, 1'b0);
      // an undecoded word only moves the pc
      step(14'h0000, 8'h55, 1'b0);
      res(8'h80, 1'b0, 1'b0);
   endtask : t_lit
   task automatic t_skip();
      step(14'h0B0A, 8'h01, 1'b0);
      res(8'h00, 1'b0, 1'b0);
      step(14'h0310, 8'h10, 1'b1);
      res(8'h00, 1'b0, 1'b0);
      step(14'h0B8A, 8'h05, 1'b0);
      res(8'h00, 1'b0, 1'b1);
      wr(7'h0A, 8'h04);
      step(14'h3801, 8'h00, 1'b0);
      res(8'h01, 1'b0, 1'b0);
      step(14'h0F8B, 8'hFF, 1'b0);
      res(8'h01, 1'b0, 1'b1);
      wr(7'h0B, 8'h00);
      step(14'h3880, 8'h00, 1'b1);
      res(8'h01, 1'b0, 1'b0);
      step(14'h0F0C, 8'h7F, 1'b0);
      res(8'h80, 1'b0, 1'b0);
      step(14'h0100, 8'h00, 1'b0);
      res(8'h00, 1'b1, 1'b0);
      step(14'h0B0D, 8'h05, 1'b0);
      res(8'h04, 1'b1, 1'b0);
   endtask : t_skip
   task automatic t_jump();
      program_counter_high_latch = 7'h5A;
      step(14'h2FFF, 8'h00, 1'b0);
      step(14'h3811, 8'h00, 1'b1);
      res(8'h04, 1'b1, 1'b0);
      program_counter_high_latch = 7'h27;
      step(14'h2800, 8'h00, 1'b0);
      idle();
      // the discarded slot is the next executed one, not the next clock
      step(14'h0100, 8'h00, 1'b1);
      res(8'h04, 1'b1, 1'b0);
   endtask : t_jump
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rstn = 1'b1;
      t_dec();
      t_lit();
      t_skip();
      t_jump();
      idle();
      report_and_stop();
   end
   // about thirty cycles are needed; over thirty times that means a hang
   initial begin
      #5000;
      n_fail++;
      report_and_stop();
   end
endmodule : alu_skip_branch_ops_test
`default_nettype wire
